/* gpio_pkg.sv */
`default_nettype none
package gpio_pkg;
  // ------------------------------------------------------------
  // data-memory map
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_PORT_A = 8'h12;
  localparam logic [7:0] ADDR_PORT_A_DIR = 8'h13;
  localparam logic [7:0] ADDR_PORT_B = 8'h14;
  localparam logic [7:0] ADDR_PORT_B_DIR = 8'h15;
  localparam logic [7:0] ADDR_PORT_C = 8'h16;
  localparam logic [7:0] ADDR_PORT_C_DIR = 8'h17;
  localparam logic [7:0] ADDR_PORT_G = 8'h1E;
  localparam logic [7:0] ADDR_PORT_G_DIR = 8'h1F;
  // ------------------------------------------------------------
  // widths and reset values
  // ------------------------------------------------------------
  localparam int PORT_W = 8;
  localparam int PORT_G_W = 3;
  localparam logic [7:0] LATCH_RST = 8'hFF;
  localparam logic [7:0] DIR_RST = 8'hFF;
  localparam logic [7:0] PORT_G_MASK = 8'h07;
  // bit positions on port b / port g
  localparam int BUZZER_TRUE_BIT = 0;
  localparam int BUZZER_INV_BIT = 1;
  localparam int INT_BIT = 0;
  // timer top: counter counts from preload up to this and wraps
  localparam logic [7:0] TIMER_TOP = 8'hFF;
  // bit-operation kinds
  typedef enum logic [1:0] {OP_SET, OP_CLR, OP_CPL} bitop_t;
endpackage
`default_nettype wire

/* pin_cell.sv */
`timescale 1ns/100ps
`default_nettype none
// one port of pad cells: output enable, drive value and pull-high
module pin_cell #(
  parameter int W = 8
) (
  input wire logic [W-1:0] latch,
  input wire logic [W-1:0] dir,
  input wire logic [W-1:0] force_val,
  input wire logic [W-1:0] force_en,
  input wire logic [W-1:0] avail,
  input wire logic pull_en,
  output logic [W-1:0] pad_out,
  output logic [W-1:0] pad_oe,
  output logic [W-1:0] pad_pullup
);
  // direction 0 means cmos output; alternate function overrides value
  assign pad_oe = ~dir & avail;
  assign pad_out = (force_en & force_val) | (~force_en & latch);
  // pull-high only on input lines; output driver wins anyway
  assign pad_pullup = {W{pull_en}} & dir & avail;
endmodule
`default_nettype wire

/* buzzer_div.sv */
`timescale 1ns/100ps
`default_nettype none
// frequency divider: toggles on every timer overflow pulse
module buzzer_div (
  input wire logic clk,
  input wire logic resetn,
  input wire logic timer_overflow,
  output logic freq_divider_out
);
  logic tog_r;
  // ------------------------------------------------------------
  // toggle flop
  // ------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
      tog_r <= 1'b0;
    else if (timer_overflow)
      tog_r <= ~tog_r;
  end
  assign freq_divider_out = tog_r;
  toggle_a: assert property (@(posedge clk) disable iff (!resetn)
    timer_overflow |=> freq_divider_out != $past(freq_divider_out))
    else $error("divider did not toggle on overflow");
endmodule
`default_nettype wire

/* gpio_ports.sv */
`timescale 1ns/100ps
`default_nettype none
// ------------------------------------------------------------
// four-port general purpose i/o with buzzer pair
// ------------------------------------------------------------
// Summary of operation
// - port latches at 12H, 14H, 16H, 1EH
// - read data samples inputs only when port read; port a also sampled every cycle for wake
// - output latch holds until rewritten
// - direction bit 1 input, 0 output
// - read gives pad if input, latch if output
// - direction registers at 13H, 15H, 17H, 1FH
// - reset makes every line input
// - bit ops read, modify, write back
// - port a lines wake from halt, per bit
// - port g upper five bits absent
// - port b lines 0,1 carry buzzer pair
// - buzzer drives outputs, inputs stay normal
// - port b bit0 latch gates buzzer
// - port g line0 is interrupt input
// - port g lines 1,2 need rc-io oscillator
// - pull-high option per port
// - port a cmos or schmitt input option
// - divider toggles on each timer overflow
module gpio_ports #(
  parameter int W = gpio_pkg::PORT_W
) (
  input wire logic clk,
  input wire logic resetn,
  // cpu data-memory side
  input wire logic [7:0] addr,
  input wire logic rd_en,
  input wire logic wr_en,
  input wire logic [7:0] wr_data,
  input wire logic bitop_en,
  input wire logic [1:0] bitop_kind,
  input wire logic [2:0] bitop_bit,
  input wire logic bitop_to_acc,
  output logic [7:0] rd_data,
  output logic rd_hit,
  // fixed options
  input wire logic [3:0] opt_pull_high,
  input wire logic opt_port_a_schmitt,
  input wire logic [7:0] opt_wake_en,
  input wire logic opt_buzzer_en,
  input wire logic opt_osc_rc_io,
  // timer overflow and halt state
  input wire logic timer_overflow,
  input wire logic halted,
  output logic wake_req,
  output logic ext_int_n,
  output logic port_a_schmitt,
  // pads
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  input wire logic [2:0] port_g_in,
  output logic [7:0] port_a_out,
  output logic [7:0] port_a_oe,
  output logic [7:0] port_a_pullup,
  output logic [7:0] port_b_out,
  output logic [7:0] port_b_oe,
  output logic [7:0] port_b_pullup,
  output logic [7:0] port_c_out,
  output logic [7:0] port_c_oe,
  output logic [7:0] port_c_pullup,
  output logic [2:0] port_g_out,
  output logic [2:0] port_g_oe,
  output logic [2:0] port_g_pullup
);
  // ------------------------------------------------------------
  // storage: index 0..3 = ports a, b, c, g
  // ------------------------------------------------------------
  logic [7:0] latch_r [4];
  logic [7:0] dir_r [4];
  logic [7:0] rd_data_r;
  logic rd_hit_r;
  logic [7:0] port_a_prev_r;
  logic wake_r;
  logic [7:0] pad_in [4];
  logic [7:0] pad_view [4];
  logic [2:0] sel;
  logic sel_dir;
  logic sel_ok;
  logic [7:0] rmw_val;
  logic [7:0] rmw_nxt;
  logic freq_div;
  logic [7:0] b_force_val;
  logic [7:0] b_force_en;
  logic [7:0] g_avail;

  // address decode: index of port and latch/direction select
  function automatic logic [2:0] port_index(input logic [7:0] a);
    case (a)
      gpio_pkg::ADDR_PORT_A, gpio_pkg::ADDR_PORT_A_DIR: port_index = 3'd0;
      gpio_pkg::ADDR_PORT_B, gpio_pkg::ADDR_PORT_B_DIR: port_index = 3'd1;
      gpio_pkg::ADDR_PORT_C, gpio_pkg::ADDR_PORT_C_DIR: port_index = 3'd2;
      gpio_pkg::ADDR_PORT_G, gpio_pkg::ADDR_PORT_G_DIR: port_index = 3'd3;
      default: port_index = 3'd4;
    endcase
  endfunction

  // width mask; port g keeps only three real bits
  function automatic logic [7:0] port_mask(input logic [2:0] i);
    port_mask = (i == 3'd3) ? gpio_pkg::PORT_G_MASK : 8'hFF;
  endfunction

  assign sel = port_index(addr);
  assign sel_dir = addr[0];
  assign sel_ok = (sel != 3'd4);

  // ------------------------------------------------------------
  // pad input view
  // ------------------------------------------------------------
  assign pad_in[0] = port_a_in;
  assign pad_in[1] = port_b_in;
  assign pad_in[2] = port_c_in;
  assign pad_in[3] = {5'h00, port_g_in};

  // pad when input, latch when output; this view feeds rmw
  always_comb
  begin
    for (int i = 0; i < 4; i++)
      pad_view[i] = ((dir_r[i] & pad_in[i]) | (~dir_r[i] & latch_r[i]))
                    & port_mask(3'(i));
  end

  assign rmw_val = sel_ok ? pad_view[sel[1:0]] : 8'h00;

  // bit operation on the whole port value
  always_comb
  begin
    rmw_nxt = rmw_val;
    case (bitop_kind)
      gpio_pkg::OP_SET: rmw_nxt[bitop_bit] = 1'b1;
      gpio_pkg::OP_CLR: rmw_nxt[bitop_bit] = 1'b0;
      gpio_pkg::OP_CPL: rmw_nxt = ~rmw_val;
      default: rmw_nxt = rmw_val;
    endcase
  end

  // ------------------------------------------------------------
  // latches and direction registers
  // ------------------------------------------------------------
  // reset leaves everything input with latches high
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < 3; i++)
      begin
        latch_r[i] <= gpio_pkg::LATCH_RST;
        dir_r[i] <= gpio_pkg::DIR_RST;
      end
      // port g has three real bits; absent ones must never hold a 1
      latch_r[3] <= gpio_pkg::LATCH_RST & gpio_pkg::PORT_G_MASK;
      dir_r[3] <= gpio_pkg::DIR_RST & gpio_pkg::PORT_G_MASK;
    end
    else if (sel_ok && !sel_dir && bitop_en && !bitop_to_acc)
      latch_r[sel[1:0]] <= rmw_nxt & port_mask(sel);
    else if (sel_ok && wr_en && !bitop_en)
    begin
      // writes to absent port g bits are dropped
      if (sel_dir)
        dir_r[sel[1:0]] <= wr_data & port_mask(sel);
      else
        latch_r[sel[1:0]] <= wr_data & port_mask(sel);
    end
  end

  // read path samples pads only in the read cycle, nothing kept
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_data_r <= 8'h00;
      rd_hit_r <= 1'b0;
    end
    else
    begin
      rd_hit_r <= sel_ok && (rd_en || (bitop_en && bitop_to_acc));
      if (sel_ok && bitop_en && bitop_to_acc)
        rd_data_r <= rmw_nxt & port_mask(sel);
      else if (sel_ok && rd_en)
        rd_data_r <= sel_dir ? (dir_r[sel[1:0]] & port_mask(sel))
                             : rmw_val;
      else
        rd_data_r <= 8'h00;
    end
  end
  assign rd_data = rd_data_r;
  assign rd_hit = rd_hit_r;

  // ------------------------------------------------------------
  // wake-up from halt on any enabled port a input line change
  // ------------------------------------------------------------
  // port a sampled every cycle; only the wake flag is gated by halted
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      port_a_prev_r <= 8'hFF;
      wake_r <= 1'b0;
    end
    else
    begin
      port_a_prev_r <= port_a_in;
      wake_r <= halted &&
        (|((port_a_in ^ port_a_prev_r) & opt_wake_en & dir_r[0]));
    end
  end
  assign wake_req = wake_r;

  // ------------------------------------------------------------
  // buzzer pair and shared pins
  // ------------------------------------------------------------
  buzzer_div u_div (
    .clk(clk),
    .resetn(resetn),
    .timer_overflow(timer_overflow),
    .freq_divider_out(freq_div)
  );

  // latch bit0 gates both pins; inputs keep normal behaviour
  always_comb
  begin
    b_force_val = 8'h00;
    b_force_en = 8'h00;
    if (opt_buzzer_en)
    begin
      b_force_en[gpio_pkg::BUZZER_TRUE_BIT] = 1'b1;
      b_force_en[gpio_pkg::BUZZER_INV_BIT] = 1'b1;
      b_force_val[gpio_pkg::BUZZER_TRUE_BIT] =
        latch_r[1][gpio_pkg::BUZZER_TRUE_BIT] & freq_div;
      b_force_val[gpio_pkg::BUZZER_INV_BIT] =
        latch_r[1][gpio_pkg::BUZZER_TRUE_BIT] & ~freq_div;
    end
  end

  // oscillator pins unusable as i/o unless rc-io mode
  assign g_avail = {5'h00, opt_osc_rc_io, opt_osc_rc_io, 1'b1};
  assign ext_int_n = port_g_in[gpio_pkg::INT_BIT];
  assign port_a_schmitt = opt_port_a_schmitt;

  pin_cell #(.W(8)) u_cell_a (
    .latch(latch_r[0]), .dir(dir_r[0]), .force_val(8'h00),
    .force_en(8'h00), .avail(8'hFF), .pull_en(opt_pull_high[0]),
    .pad_out(port_a_out), .pad_oe(port_a_oe), .pad_pullup(port_a_pullup)
  );
  pin_cell #(.W(8)) u_cell_b (
    .latch(latch_r[1]), .dir(dir_r[1]), .force_val(b_force_val),
    .force_en(b_force_en), .avail(8'hFF), .pull_en(opt_pull_high[1]),
    .pad_out(port_b_out), .pad_oe(port_b_oe), .pad_pullup(port_b_pullup)
  );
  pin_cell #(.W(8)) u_cell_c (
    .latch(latch_r[2]), .dir(dir_r[2]), .force_val(8'h00),
    .force_en(8'h00), .avail(8'hFF), .pull_en(opt_pull_high[2]),
    .pad_out(port_c_out), .pad_oe(port_c_oe), .pad_pullup(port_c_pullup)
  );
  pin_cell #(.W(3)) u_cell_g (
    .latch(latch_r[3][2:0]), .dir(dir_r[3][2:0]), .force_val(3'h0),
    .force_en(3'h0), .avail(g_avail[2:0]), .pull_en(opt_pull_high[3]),
    .pad_out(port_g_out), .pad_oe(port_g_oe), .pad_pullup(port_g_pullup)
  );

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  sequence latch_write_s;
    wr_en && !bitop_en && addr == gpio_pkg::ADDR_PORT_A;
  endsequence
  latch_write_a: assert property (@(posedge clk) disable iff (!resetn)
    latch_write_s |=> latch_r[0] == $past(wr_data))
    else $error("port a latch not written");
  dir_write_a: assert property (@(posedge clk) disable iff (!resetn)
    wr_en && !bitop_en && addr == gpio_pkg::ADDR_PORT_B_DIR
    |=> dir_r[1] == $past(wr_data))
    else $error("port b direction not written");
  latch_hold_a: assert property (@(posedge clk) disable iff (!resetn)
    !wr_en && !bitop_en |=> latch_r[2] == $past(latch_r[2]))
    else $error("port c latch changed without write");
  read_select_a: assert property (@(posedge clk) disable iff (!resetn)
    rd_en && !bitop_en && addr == gpio_pkg::ADDR_PORT_C
    |=> rd_data == $past((dir_r[2] & port_c_in) | (~dir_r[2] & latch_r[2])))
    else $error("port read source wrong");
  port_g_top_a: assert property (@(posedge clk) disable iff (!resetn)
    latch_r[3][7:3] == 5'h00 && dir_r[3][7:3] == 5'h00)
    else $error("absent port g bits set");
  output_dir_a: assert property (@(posedge clk) disable iff (!resetn)
    port_c_oe == ~dir_r[2])
    else $error("port c enable not from direction");
  buzzer_gate_a: assert property (@(posedge clk) disable iff (!resetn)
    opt_buzzer_en && !latch_r[1][0] && !dir_r[1][1]
    |-> port_b_oe[1] && !port_b_out[1] && !port_b_out[0])
    else $error("buzzer not gated low");
  osc_pins_a: assert property (@(posedge clk) disable iff (!resetn)
    !opt_osc_rc_io |-> port_g_oe[2:1] == 2'b00 && port_g_pullup[2:1] == 2'b00)
    else $error("oscillator pins used as i/o");
  wake_a: assert property (@(posedge clk) disable iff (!resetn)
    !halted |=> !wake_req)
    else $error("wake outside halt");
endmodule
`default_nettype wire

/* pad_model.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// pins, load and far-side sources
// ----------------------------------------
module pad_model #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic [W-1:0] out,
  input wire logic [W-1:0] oe,
  input wire logic [W-1:0] pull_on,
  input wire logic [W-1:0] ext_val,
  input wire logic [W-1:0] ext_en,
  output logic [W-1:0] pin
);
  logic tgl_r;
  // a floating line keeps changing so a stale value never reads as good
  always @(posedge clk)
  begin
    tgl_r <= ~tgl_r;
  end
  initial tgl_r = 1'b0;
  // device drive wins, then outside source, then pull resistor
  always_comb
  begin
    for (int i = 0; i < W; i++)
    begin
      if (oe[i])
        pin[i] = out[i];
      else if (ext_en[i])
        pin[i] = ext_val[i];
      else if (pull_on[i])
        pin[i] = 1'b1;
      else
        pin[i] = tgl_r;
    end
  end
endmodule
`default_nettype wire

/* gpio_ports_tb.sv */
`timescale 1ns/100ps
`default_nettype none
// ----------------------------------------
// port block testbench
// ----------------------------------------
module gpio_ports_tb;
  logic clk, resetn, rd_en, wr_en, bitop_en, bitop_to_acc;
  logic [7:0] addr, wr_data, rd_data, opt_wake_en, ext_a;
  logic [1:0] bitop_kind;
  logic [2:0] bitop_bit, g_in, g_out, g_oe, g_pu;
  logic [3:0] opt_pull_high;
  logic opt_port_a_schmitt, opt_buzzer_en, opt_osc_rc_io, timer_overflow;
  logic halted, wake_req, ext_int_n, port_a_schmitt, rd_hit;
  logic [7:0] a_in, a_out, a_oe, a_pu, b_in, b_out, b_oe, b_pu;
  logic [7:0] c_in, c_out, c_oe, c_pu;
  logic [7:0] ext_a_en, ext_b, ext_b_en, ext_c, ext_c_en;
  logic [2:0] ext_g, ext_g_en;
  int bad_count, cmp_count;
  gpio_ports DUT (.clk(clk), .resetn(resetn), .addr(addr), .rd_en(rd_en),
    .wr_en(wr_en), .wr_data(wr_data), .bitop_en(bitop_en),
    .bitop_kind(bitop_kind), .bitop_bit(bitop_bit),
    .bitop_to_acc(bitop_to_acc), .rd_data(rd_data), .rd_hit(rd_hit),
    .opt_pull_high(opt_pull_high), .opt_port_a_schmitt(opt_port_a_schmitt),
    .opt_wake_en(opt_wake_en), .opt_buzzer_en(opt_buzzer_en),
    .opt_osc_rc_io(opt_osc_rc_io), .timer_overflow(timer_overflow),
    .halted(halted), .wake_req(wake_req), .ext_int_n(ext_int_n),
    .port_a_schmitt(port_a_schmitt), .port_a_in(a_in), .port_b_in(b_in),
    .port_c_in(c_in), .port_g_in(g_in), .port_a_out(a_out),
    .port_a_oe(a_oe), .port_a_pullup(a_pu), .port_b_out(b_out),
    .port_b_oe(b_oe), .port_b_pullup(b_pu), .port_c_out(c_out),
    .port_c_oe(c_oe), .port_c_pullup(c_pu), .port_g_out(g_out),
    .port_g_oe(g_oe), .port_g_pullup(g_pu));
  pad_model #(.W(8)) pad_a (.clk(clk), .out(a_out), .oe(a_oe),
    .pull_on(a_pu), .ext_val(ext_a), .ext_en(ext_a_en), .pin(a_in));
  pad_model #(.W(8)) pad_b (.clk(clk), .out(b_out), .oe(b_oe),
    .pull_on(b_pu), .ext_val(ext_b), .ext_en(ext_b_en), .pin(b_in));
  pad_model #(.W(8)) pad_c (.clk(clk), .out(c_out), .oe(c_oe),
    .pull_on(c_pu), .ext_val(ext_c), .ext_en(ext_c_en), .pin(c_in));
  pad_model #(.W(3)) pad_g (.clk(clk), .out(g_out), .oe(g_oe),
    .pull_on(g_pu), .ext_val(ext_g), .ext_en(ext_g_en), .pin(g_in));
  // clock, 8 ns period
  always #4 clk = ~clk;
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    cmp_count++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wr_data <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    #1;
  endtask
  // read answers on the edge that takes rd_en, checked 1 ns later
  task automatic rd(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1;
    chk("rd_hit", {7'h00, h}, {7'h00, rd_hit});
    chk("rd_data", e, rd_data);
  endtask
  task automatic bop(input logic [1:0] k, input logic [2:0] b,
    input logic [7:0] a, input logic acc, input logic [7:0] e);
    @(posedge clk);
    addr <= a;
    bitop_kind <= k;
    bitop_bit <= b;
    bitop_to_acc <= acc;
    bitop_en <= 1'b1;
    @(posedge clk);
    bitop_en <= 1'b0;
    #1;
    if (acc)
      chk("acc", e, rd_data);
  endtask
  // wake pulse must show within four cycles
  task automatic chk_wake(input logic e);
    logic seen;
    seen = 1'b0;
    repeat (4)
    begin
      @(posedge clk);
      #1;
      if (wake_req === 1'b1)
        seen = 1'b1;
    end
    chk("wake_req", {7'h00, e}, {7'h00, seen});
  endtask
  task automatic print_verdict;
    if (bad_count == 0 && cmp_count > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // watchdog, far beyond the fewer than a hundred cycles of the tests
  initial
  begin
    #200000;
    bad_count++;
    print_verdict();
  end
  initial
  begin
    clk = 0; resetn = 0; addr = 0; rd_en = 0; wr_en = 0; wr_data = 0;
    bitop_en = 0; bitop_kind = 0; bitop_bit = 0; bitop_to_acc = 0;
    opt_pull_high = 4'h5; opt_port_a_schmitt = 1; opt_wake_en = 8'h01;
    opt_buzzer_en = 0; opt_osc_rc_io = 1; timer_overflow = 0; halted = 0;
    ext_a = 8'h00; bad_count = 0; cmp_count = 0;
    ext_a_en = 8'hFF;
    ext_b = 8'h00;
    ext_b_en = 8'h00;
    ext_c = 8'h00;
    ext_c_en = 8'h00;
    // an outside source holds the interrupt line low when it is an input
    ext_g = 3'h0;
    ext_g_en = 3'h1;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("a_oe", 8'h00, a_oe);
    chk("pulls", 8'hB0, {a_pu[0], b_pu[0], c_pu[0], 5'h10});
    chk("g_pu", 8'h00, {5'h00, g_pu});
    chk("schmitt", 8'h01, {7'h00, port_a_schmitt});
    rd(gpio_pkg::ADDR_PORT_A_DIR, 8'hFF, 1'b1);
    rd(gpio_pkg::ADDR_PORT_G_DIR, 8'h07, 1'b1);
    rd(8'h20, 8'h00, 1'b0);
    // halted: a masked line stays quiet, an enabled one wakes
    @(posedge clk);
    halted <= 1'b1;
    ext_a <= 8'h02;
    chk_wake(1'b0);
    ext_a <= 8'h03;
    chk_wake(1'b1);
    halted <= 1'b0;
    rd(gpio_pkg::ADDR_PORT_A, 8'h03, 1'b1);
    wr(gpio_pkg::ADDR_PORT_A, 8'h5A);
    wr(gpio_pkg::ADDR_PORT_A_DIR, 8'hF0);
    chk("a_oe", 8'h0F, a_oe);
    chk("a_out", 8'h5A, a_out);
    @(posedge clk);
    ext_a <= 8'h3C;
    rd(gpio_pkg::ADDR_PORT_A, 8'h3A, 1'b1);
    // read-modify-write on port c
    wr(gpio_pkg::ADDR_PORT_C_DIR, 8'h00);
    chk("c_oe", 8'hFF, c_oe);
    wr(gpio_pkg::ADDR_PORT_C, 8'h00);
    bop(gpio_pkg::OP_SET, 3'h7, gpio_pkg::ADDR_PORT_C, 1'b0, 8'h00);
    bop(gpio_pkg::OP_CPL, 3'h0, gpio_pkg::ADDR_PORT_C, 1'b0, 8'h00);
    bop(gpio_pkg::OP_CLR, 3'h0, gpio_pkg::ADDR_PORT_C, 1'b0, 8'h00);
    bop(gpio_pkg::OP_SET, 3'h7, gpio_pkg::ADDR_PORT_C, 1'b1, 8'hFE);
    rd(gpio_pkg::ADDR_PORT_C, 8'h7E, 1'b1);
    chk("c_out", 8'h7E, c_out);
    // port g: three lines only, line 0 feeds the interrupt
    wr(gpio_pkg::ADDR_PORT_G_DIR, 8'h00);
    wr(gpio_pkg::ADDR_PORT_G, 8'hFA);
    rd(gpio_pkg::ADDR_PORT_G, 8'h02, 1'b1);
    chk("g_oe", 8'h07, {5'h00, g_oe});
    chk("int_n", 8'h00, {7'h00, ext_int_n});
    wr(gpio_pkg::ADDR_PORT_G, 8'hFF);
    chk("int_n", 8'h01, {7'h00, ext_int_n});
    // line 0 back to input: the outside source now pulls it low
    wr(gpio_pkg::ADDR_PORT_G_DIR, 8'h01);
    chk("int_n", 8'h00, {7'h00, ext_int_n});
    // second reset with buzzer on and crystal oscillator mode
    @(posedge clk);
    resetn <= 1'b0;
    opt_osc_rc_io <= 1'b0;
    opt_buzzer_en <= 1'b1;
    opt_pull_high <= 4'hF;
    repeat (12) @(posedge clk);
    resetn <= 1'b1;
    #1;
    chk("g_pu", 8'h01, {5'h00, g_pu});
    rd(gpio_pkg::ADDR_PORT_B_DIR, 8'hFF, 1'b1);
    // port c inputs: low nibble driven outside, high nibble on pull-high
    @(posedge clk);
    ext_c_en <= 8'h0F;
    ext_c <= 8'h05;
    rd(gpio_pkg::ADDR_PORT_C, 8'hF5, 1'b1);
    wr(gpio_pkg::ADDR_PORT_B_DIR, 8'h00);
    chk("b_oe", 8'hFF, b_oe);
    chk("bz", 8'h02, {6'h00, b_out[1:0]});
    @(posedge clk);
    timer_overflow <= 1'b1;
    @(posedge clk);
    timer_overflow <= 1'b0;
    #1;
    chk("bz", 8'h01, {6'h00, b_out[1:0]});
    wr(gpio_pkg::ADDR_PORT_B, 8'hFE);
    chk("bz", 8'h00, {6'h00, b_out[1:0]});
    wr(gpio_pkg::ADDR_PORT_G_DIR, 8'h00);
    chk("g_oe", 8'h01, {5'h00, g_oe});
    print_verdict();
  end
endmodule
`default_nettype wire
